// ==== src/dma_slot_channel.sv ====
// DMA channel: APB registers, slot selection and byte data path
// Notes on behaviour
// [R1] Each channel has fourteen slot-select bits; a one claims that codec slot.
// [R2] Data moves only during slots whose select bit is set.
// [R3] Transfer direction comes from this channel's control direction bit.
// [R4] Firmware sets slot-select bits before turning the channel on.
// [R5] Low slot register holds select bits 7:0, all read/write.
// [R6] High slot register holds select bits 13:8 in bits 5:0.
// [R7] High register bits 7:6 give one to four bytes per slot.
// [R8] Control: bit7 go, bit6 circular, 5:4 reserved, bit3 direction, 2:0 endpoint.
// [R9] Writing one to go activates the channel; configure everything first.
// [R10] Direction one serves a USB IN endpoint, zero an OUT endpoint.
// [R11] Endpoint field selects 1..7; endpoint zero never runs DMA.
// [R12] Circular buffer bit is seen by the channel and buffer manager. The channel does not use it; it only drives it out on circular_buffer_on_out.
`timescale 1ns/100ps
module dma_slot_channel
  import dma_slot_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [APB_DATA_W-1:0] pwdata,
  output logic [APB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slot_start_in,
  input wire logic [SLOT_NUM_W-1:0] slot_num_in,
  input wire logic cp_rx_valid_in,
  input wire logic [BYTE_W-1:0] cp_rx_data_in,
  output logic cp_rx_ready_out,
  output logic cp_tx_valid_out,
  output logic [BYTE_W-1:0] cp_tx_data_out,
  input wire logic cp_tx_ready_in,
  input wire logic usb_rd_valid_in,
  input wire logic [BYTE_W-1:0] usb_rd_data_in,
  output logic usb_rd_ready_out,
  output logic usb_wr_valid_out,
  output logic [BYTE_W-1:0] usb_wr_data_out,
  input wire logic usb_wr_ready_in,
  output logic [EP_W-1:0] endpoint_index_out,
  output logic endpoint_direction_out,
  output logic circular_buffer_on_out,
  output logic channel_busy_out
);

  logic [REG_W-1:0] ctrl_q;
  logic [REG_W-1:0] slot_hi_q;
  logic [REG_W-1:0] slot_lo_q;
  logic [APB_DATA_W-1:0] prdata_q;
  logic [SLOT_COUNT-1:0] slot_select_bits;
  logic [1:0] slot_byte_count;
  logic channel_go;
  logic circular_buffer_on;
  logic endpoint_direction;
  logic [EP_W-1:0] endpoint_index;
  logic ep_valid;
  logic moving;
  logic [COUNT_W-1:0] remaining;
  logic src_valid;
  logic [BYTE_W-1:0] src_data;
  logic src_ready;
  logic step;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [BYTE_W-1:0] buf_out_data;
  logic [LEVEL_W-1:0] buf_level;
  logic setup;
  logic wr_access;
  logic [REG_IDX_W-1:0] req_idx;

  function automatic logic idx_mapped(input logic [REG_IDX_W-1:0] idx);
    return (idx == CTRL_IDX) || (idx == SLOT_HI_IDX) || (idx == SLOT_LO_IDX) || (idx == STATUS_IDX);
  endfunction : idx_mapped

  // Register fields
  // [R1] fourteen select bits
  assign slot_select_bits = {slot_hi_q[SH_SEL_W-1:0], slot_lo_q};
  assign slot_byte_count = slot_hi_q[SH_BYTES_LSB +: 2];
  assign channel_go = ctrl_q[CTRL_GO_BIT];
  assign circular_buffer_on = ctrl_q[CTRL_CIRC_BIT];
  assign endpoint_direction = ctrl_q[CTRL_DIR_BIT];
  assign endpoint_index = ctrl_q[CTRL_EP_LSB +: EP_W];
  // [R11] endpoint zero excluded
  assign ep_valid = (endpoint_index != EP_CONTROL);

  // APB slave: zero wait states, read data captured in setup phase
  assign req_idx = paddr[APB_ADDR_W-1:2];
  assign setup = psel && !penable;
  assign wr_access = psel && penable && pwrite && idx_mapped(req_idx);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !idx_mapped(req_idx);
  assign prdata = prdata_q;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      prdata_q <= '0;
    end else if (setup && !pwrite) begin
      unique case (req_idx)
        CTRL_IDX: prdata_q <= {24'h000000, ctrl_q};
        SLOT_HI_IDX: prdata_q <= {24'h000000, slot_hi_q};
        SLOT_LO_IDX: prdata_q <= {24'h000000, slot_lo_q};
        STATUS_IDX: begin
          prdata_q <= '0;
          prdata_q[ST_BUSY_BIT] <= moving;
          prdata_q[ST_REM_LSB +: COUNT_W] <= remaining;
          prdata_q[ST_LEVEL_LSB +: LEVEL_W] <= buf_level;
        end
        default: prdata_q <= '0;
      endcase
    end
  end

  // [R8] control layout, reserved bits held at zero
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_access && req_idx == CTRL_IDX) begin
      ctrl_q <= pwdata[REG_W-1:0] & CTRL_WMASK;
    end
  end

  // [R6] [R7] high select bits and byte count
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      slot_hi_q <= SLOT_HI_RESET;
    end else if (wr_access && req_idx == SLOT_HI_IDX) begin
      slot_hi_q <= pwdata[REG_W-1:0];
    end
  end

  // [R5] low select bits
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      slot_lo_q <= SLOT_LO_RESET;
    end else if (wr_access && req_idx == SLOT_LO_IDX) begin
      slot_lo_q <= pwdata[REG_W-1:0];
    end
  end

  // [R2] [R9] slots claimed only when on
  slot_sequencer u_seq (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .go_in(channel_go),
    .ep_valid_in(ep_valid),
    .slot_start_in(slot_start_in),
    .slot_num_in(slot_num_in),
    .select_in(slot_select_bits),
    .byte_code_in(slot_byte_count),
    .step_in(step),
    .moving_out(moving),
    .remaining_out(remaining)
  );

  // [R3] [R10] direction picks source and sink
  // IN: codec data register to USB buffer; OUT: USB buffer to codec
  assign src_valid = (endpoint_direction == DIR_IN) ? cp_rx_valid_in : usb_rd_valid_in;
  assign src_data = (endpoint_direction == DIR_IN) ? cp_rx_data_in : usb_rd_data_in;
  assign src_ready = moving && buf_in_ready;
  assign step = src_ready && src_valid;
  assign cp_rx_ready_out = src_ready && (endpoint_direction == DIR_IN);
  assign usb_rd_ready_out = src_ready && (endpoint_direction != DIR_IN);

  // Stalled sink fills the buffer, which then holds off the source
  byte_buffer #(
    .WIDTH(BYTE_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .in_valid_in(moving && src_valid),
    .in_data_in(src_data),
    .in_ready_out(buf_in_ready),
    .out_valid_out(buf_out_valid),
    .out_data_out(buf_out_data),
    .out_ready_in(buf_out_ready),
    .level_out(buf_level)
  );

  // Flipping direction with bytes buffered sends them the new way
  assign buf_out_ready = (endpoint_direction == DIR_IN) ? usb_wr_ready_in : cp_tx_ready_in;
  assign usb_wr_valid_out = buf_out_valid && (endpoint_direction == DIR_IN);
  assign cp_tx_valid_out = buf_out_valid && (endpoint_direction != DIR_IN);
  assign usb_wr_data_out = buf_out_data;
  assign cp_tx_data_out = buf_out_data;

  // [R12] circular mode visible to buffer manager
  assign circular_buffer_on_out = circular_buffer_on;
  assign endpoint_index_out = endpoint_index;
  assign endpoint_direction_out = endpoint_direction;
  assign channel_busy_out = moving;

  property p_claim_selected;
    @(posedge ref_clk_in) disable iff (rst_in)
      (!moving && slot_start_in && channel_go && ep_valid && slot_num_in < SLOT_NUM_W'(SLOT_COUNT)
       && slot_select_bits[slot_num_in]) |=> moving;
  endproperty
  a_claim_selected: assert property (p_claim_selected) else $error("selected slot not claimed"); // [R1]

  property p_skip_unselected;
    @(posedge ref_clk_in) disable iff (rst_in)
      (!moving && !(slot_start_in && slot_num_in < SLOT_NUM_W'(SLOT_COUNT) && slot_select_bits[slot_num_in]))
      |=> !moving;
  endproperty
  a_skip_unselected: assert property (p_skip_unselected) else $error("unselected slot moved data"); // [R2]

  property p_dir_sink;
    @(posedge ref_clk_in) disable iff (rst_in)
      endpoint_direction |-> (!cp_tx_valid_out && !usb_rd_ready_out);
  endproperty
  a_dir_sink: assert property (p_dir_sink) else $error("IN channel touched OUT path"); // [R3]

  property p_low_write;
    @(posedge ref_clk_in) disable iff (rst_in)
      (wr_access && req_idx == SLOT_LO_IDX) |=> slot_select_bits[REG_W-1:0] == $past(pwdata[REG_W-1:0]);
  endproperty
  a_low_write: assert property (p_low_write) else $error("low select write lost"); // [R5]

  property p_high_write;
    @(posedge ref_clk_in) disable iff (rst_in)
      (wr_access && req_idx == SLOT_HI_IDX) |=>
        slot_select_bits[SLOT_COUNT-1:REG_W] == $past(pwdata[SH_SEL_W-1:0]);
  endproperty
  a_high_write: assert property (p_high_write) else $error("high select write lost"); // [R6]

  property p_byte_load;
    @(posedge ref_clk_in) disable iff (rst_in)
      $rose(moving) |-> remaining == slot_bytes($past(slot_byte_count));
  endproperty
  a_byte_load: assert property (p_byte_load) else $error("wrong bytes per slot"); // [R7]

  property p_reserved_zero;
    @(posedge ref_clk_in) disable iff (rst_in)
      (wr_access && req_idx == CTRL_IDX) |=> (ctrl_q == ($past(pwdata[REG_W-1:0]) & CTRL_WMASK));
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("control layout wrong"); // [R8]

  property p_off_idle;
    @(posedge ref_clk_in) disable iff (rst_in)
      !channel_go |=> !moving;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("channel moved while off"); // [R9]

  property p_out_path;
    @(posedge ref_clk_in) disable iff (rst_in)
      !endpoint_direction |-> (!usb_wr_valid_out && !cp_rx_ready_out);
  endproperty
  a_out_path: assert property (p_out_path) else $error("OUT channel touched IN path"); // [R10]

  property p_ep_zero;
    @(posedge ref_clk_in) disable iff (rst_in)
      (!moving && !ep_valid) |=> !moving;
  endproperty
  a_ep_zero: assert property (p_ep_zero) else $error("endpoint zero ran DMA"); // [R11]

  property p_circ_out;
    @(posedge ref_clk_in) disable iff (rst_in)
      (wr_access && req_idx == CTRL_IDX) |=> circular_buffer_on_out == $past(pwdata[CTRL_CIRC_BIT]);
  endproperty
  a_circ_out: assert property (p_circ_out) else $error("circular flag not exported"); // [R12]

  property p_last_byte;
    @(posedge ref_clk_in) disable iff (rst_in)
      (moving && channel_go && step && remaining == COUNT_W'(1)) |=> !moving;
  endproperty
  a_last_byte: assert property (p_last_byte) else $error("slot overran its byte count"); // [R7]

  property p_byte_step;
    @(posedge ref_clk_in) disable iff (rst_in)
      (moving && channel_go && step && remaining != COUNT_W'(1)) |=>
        (moving && remaining == $past(remaining) - COUNT_W'(1));
  endproperty
  a_byte_step: assert property (p_byte_step) else $error("byte count did not step"); // [R7]

  property p_idle_sources;
    @(posedge ref_clk_in) disable iff (rst_in)
      !moving |-> (!cp_rx_ready_out && !usb_rd_ready_out);
  endproperty
  a_idle_sources: assert property (p_idle_sources) else $error("byte taken outside a slot"); // [R2]

  property p_go_abort;
    @(posedge ref_clk_in) disable iff (rst_in)
      (moving && !channel_go) |=> !moving;
  endproperty
  a_go_abort: assert property (p_go_abort) else $error("slot kept running after go cleared"); // [R9]

  property p_low_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
      !(wr_access && req_idx == SLOT_LO_IDX) |=> $stable(slot_lo_q);
  endproperty
  a_low_hold: assert property (p_low_hold) else $error("low select changed without write"); // [R5]

  property p_high_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
      !(wr_access && req_idx == SLOT_HI_IDX) |=> $stable(slot_hi_q);
  endproperty
  a_high_hold: assert property (p_high_hold) else $error("high select changed without write"); // [R6]

  property p_in_route;
    @(posedge ref_clk_in) disable iff (rst_in)
      (moving && endpoint_direction == DIR_IN && buf_in_ready) |-> cp_rx_ready_out;
  endproperty
  a_in_route: assert property (p_in_route) else $error("IN channel not taking codec bytes"); // [R10]

endmodule : dma_slot_channel

// ==== src/dma_slot_pkg.sv ====
// Shared constants and types for the slot-driven DMA channel
package dma_slot_pkg;

  localparam int unsigned APB_ADDR_W = 18;
  localparam int unsigned APB_DATA_W = 32;
  localparam int unsigned REG_IDX_W = 16;
  localparam int unsigned REG_W = 8;

  // Register indices; byte address is four times the index
  localparam logic [15:0] CTRL_IDX = 16'hfff4;
  localparam logic [15:0] SLOT_HI_IDX = 16'hfff5;
  localparam logic [15:0] SLOT_LO_IDX = 16'hfff6;
  localparam logic [15:0] STATUS_IDX = 16'hfff7;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] SLOT_HI_RESET = 8'h00;
  localparam logic [7:0] SLOT_LO_RESET = 8'h00;
  // Bits 5:4 of control are reserved and read as zero
  localparam logic [7:0] CTRL_WMASK = 8'hcf;

  localparam int unsigned CTRL_GO_BIT = 7;
  localparam int unsigned CTRL_CIRC_BIT = 6;
  localparam int unsigned CTRL_DIR_BIT = 3;
  localparam int unsigned CTRL_EP_LSB = 0;
  localparam int unsigned SH_SEL_W = 6;
  localparam int unsigned SH_BYTES_LSB = 6;

  localparam int unsigned SLOT_COUNT = 14;
  localparam int unsigned SLOT_NUM_W = 4;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned EP_W = 3;
  localparam int unsigned COUNT_W = 3;
  localparam int unsigned BUF_DEPTH = 2;
  localparam int unsigned LEVEL_W = 2;

  localparam logic DIR_IN = 1'b1;
  localparam logic [2:0] EP_CONTROL = 3'h0;

  // Status register layout
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_REM_LSB = 1;
  localparam int unsigned ST_LEVEL_LSB = 4;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_MOVE = 2'b01
  } seq_state_t;

  // Byte-count code 00..11 means 1..4 bytes per slot
  function automatic logic [2:0] slot_bytes(input logic [1:0] code);
    return {1'b0, code} + 3'h1;
  endfunction : slot_bytes

endpackage : dma_slot_pkg

// ==== src/byte_buffer.sv ====
// Two-entry byte buffer with valid/ready on both sides
`timescale 1ns/100ps
module byte_buffer
  import dma_slot_pkg::*;
#(
  parameter int unsigned WIDTH = BYTE_W,
  parameter int unsigned DEPTH = BUF_DEPTH
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in,
  output logic [$clog2(DEPTH+1)-1:0] level_out
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned LVL_W = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [LVL_W-1:0] level_q;
  logic push;
  logic pop;

  assign in_ready_out = (level_q != LVL_W'(DEPTH));
  assign out_valid_out = (level_q != '0);
  assign out_data_out = mem_q[rd_ptr_q];
  assign level_out = level_q;
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      level_q <= '0;
    end else if (push && !pop) begin
      level_q <= level_q + 1'b1;
    end else if (pop && !push) begin
      level_q <= level_q - 1'b1;
    end
  end

endmodule : byte_buffer

// ==== src/slot_sequencer.sv ====
// Per-slot byte sequencer: claims selected slots and counts bytes
`timescale 1ns/100ps
module slot_sequencer
  import dma_slot_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic go_in,
  input wire logic ep_valid_in,
  input wire logic slot_start_in,
  input wire logic [SLOT_NUM_W-1:0] slot_num_in,
  input wire logic [SLOT_COUNT-1:0] select_in,
  input wire logic [1:0] byte_code_in,
  input wire logic step_in,
  output logic moving_out,
  output logic [COUNT_W-1:0] remaining_out
);

  seq_state_t state_q;
  logic [COUNT_W-1:0] remaining_q;
  logic claim;

  // Slot numbers 14 and 15 are never selected
  assign claim = go_in && ep_valid_in && slot_start_in &&
                 (slot_num_in < SLOT_NUM_W'(SLOT_COUNT)) && select_in[slot_num_in];
  assign moving_out = (state_q == SEQ_MOVE);
  assign remaining_out = remaining_q;

  // A start arriving mid-slot is ignored: the previous slot still drains
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_q <= SEQ_IDLE;
      remaining_q <= '0;
    end else begin
      unique case (state_q)
        SEQ_IDLE: begin
          if (claim) begin
            state_q <= SEQ_MOVE;
            remaining_q <= slot_bytes(byte_code_in);
          end
        end
        SEQ_MOVE: begin
          if (!go_in) begin
            state_q <= SEQ_IDLE;
            remaining_q <= '0;
          end else if (step_in) begin
            remaining_q <= remaining_q - 1'b1;
            if (remaining_q == COUNT_W'(1)) begin
              state_q <= SEQ_IDLE;
            end
          end
        end
        default: begin
          state_q <= SEQ_IDLE;
          remaining_q <= '0;
        end
      endcase
    end
  end

endmodule : slot_sequencer

// ==== tb/stream_partner.sv ====
// Codec port and USB buffer stand-in: counting byte sources, stallable sinks
`timescale 1ns/100ps
module stream_partner (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic stall_in,
  input wire logic cp_rx_ready_in,
  output logic cp_rx_valid_out,
  output logic [7:0] cp_rx_data_out,
  input wire logic usb_rd_ready_in,
  output logic usb_rd_valid_out,
  output logic [7:0] usb_rd_data_out,
  input wire logic cp_tx_valid_in,
  input wire logic [7:0] cp_tx_data_in,
  output logic cp_tx_ready_out,
  input wire logic usb_wr_valid_in,
  input wire logic [7:0] usb_wr_data_in,
  output logic usb_wr_ready_out,
  output logic [7:0] cp_got_out,
  output logic [7:0] usb_got_out,
  output logic [7:0] cp_last_out,
  output logic [7:0] usb_last_out
);
  // Sinks stall together so the buffer sees back-pressure
  assign cp_tx_ready_out = !stall_in;
  assign usb_wr_ready_out = !stall_in;

  // Sources hold valid high; data steps on each take
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cp_rx_valid_out <= 1'b0;
      usb_rd_valid_out <= 1'b0;
      cp_rx_data_out <= 8'h10;
      usb_rd_data_out <= 8'h80;
    end else begin
      cp_rx_valid_out <= 1'b1;
      usb_rd_valid_out <= 1'b1;
      if (cp_rx_valid_out && cp_rx_ready_in) begin
        cp_rx_data_out <= cp_rx_data_out + 8'h01;
      end
      if (usb_rd_valid_out && usb_rd_ready_in) begin
        usb_rd_data_out <= usb_rd_data_out + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cp_got_out <= 8'h00;
      usb_got_out <= 8'h00;
      cp_last_out <= 8'h00;
      usb_last_out <= 8'h00;
    end else begin
      if (cp_tx_valid_in && cp_tx_ready_out) begin
        cp_got_out <= cp_got_out + 8'h01;
        cp_last_out <= cp_tx_data_in;
      end
      if (usb_wr_valid_in && usb_wr_ready_out) begin
        usb_got_out <= usb_got_out + 8'h01;
        usb_last_out <= usb_wr_data_in;
      end
    end
  end
endmodule : stream_partner

// ==== tb/tb_dma_slot_channel.sv ====
// Self-checking bench for the slot-driven DMA channel
`timescale 1ns/100ps
module tb_dma_slot_channel;
  import dma_slot_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slot_start = 1'b0, stall = 1'b0;
  logic [APB_ADDR_W-1:0] paddr = '0;
  logic [APB_DATA_W-1:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, dir, circ, busy;
  logic [SLOT_NUM_W-1:0] slot_num = '0;
  logic cp_rx_valid, cp_rx_ready, cp_tx_valid, cp_tx_ready, usb_rd_valid, usb_rd_ready, usb_wr_valid, usb_wr_ready;
  logic [7:0] cp_rx_data, cp_tx_data, usb_rd_data, usb_wr_data, cp_got, usb_got, cp_last, usb_last;
  logic [EP_W-1:0] ep;
  int errors = 0, tests_run = 0, in_tot = 0;
  always #50 clk = ~clk;

  dma_slot_channel dma_slot_channel_i (.ref_clk_in(clk), .rst_in(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slot_start_in(slot_start), .slot_num_in(slot_num), .cp_rx_valid_in(cp_rx_valid), .cp_rx_data_in(cp_rx_data),
    .cp_rx_ready_out(cp_rx_ready), .cp_tx_valid_out(cp_tx_valid), .cp_tx_data_out(cp_tx_data),
    .cp_tx_ready_in(cp_tx_ready), .usb_rd_valid_in(usb_rd_valid), .usb_rd_data_in(usb_rd_data),
    .usb_rd_ready_out(usb_rd_ready), .usb_wr_valid_out(usb_wr_valid), .usb_wr_data_out(usb_wr_data),
    .usb_wr_ready_in(usb_wr_ready), .endpoint_index_out(ep), .endpoint_direction_out(dir),
    .circular_buffer_on_out(circ), .channel_busy_out(busy));

  stream_partner stream_partner_i (.ref_clk_in(clk), .rst_in(rst), .stall_in(stall), .cp_rx_ready_in(cp_rx_ready),
    .cp_rx_valid_out(cp_rx_valid), .cp_rx_data_out(cp_rx_data), .usb_rd_ready_in(usb_rd_ready),
    .usb_rd_valid_out(usb_rd_valid), .usb_rd_data_out(usb_rd_data), .cp_tx_valid_in(cp_tx_valid),
    .cp_tx_data_in(cp_tx_data), .cp_tx_ready_out(cp_tx_ready), .usb_wr_valid_in(usb_wr_valid),
    .usb_wr_data_in(usb_wr_data), .usb_wr_ready_out(usb_wr_ready), .cp_got_out(cp_got),
    .usb_got_out(usb_got), .cp_last_out(cp_last), .usb_last_out(usb_last));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    // The wait ends on the first edge that sees pready high
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rw(input logic [15:0] idx, input logic [7:0] wd, input logic [31:0] exp);
    apb(1'b1, idx, wd);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask : rw

  // Pulse one slot start, then let the slot finish and the buffer drain
  task automatic slot(input logic [3:0] n);
    int k;
    @(posedge clk);
    slot_num <= n;
    slot_start <= 1'b1;
    @(posedge clk);
    slot_start <= 1'b0;
    for (k = 0; k < 30; k++) begin
      @(posedge clk);
      if (k > 1 && busy !== 1'b1) break;
    end
    repeat (4) @(posedge clk);
  endtask : slot

  task automatic t_regs;
    apb(1'b0, CTRL_IDX, 8'h00);
    chk(rd, 32'h0);
    apb(1'b0, SLOT_HI_IDX, 8'h00);
    chk(rd, 32'h0);
    apb(1'b0, SLOT_LO_IDX, 8'h00);
    chk(rd, 32'h0);
    rw(SLOT_LO_IDX, 8'ha5, 32'ha5);
    rw(SLOT_HI_IDX, 8'h5a, 32'h5a);
    rw(CTRL_IDX, 8'hff, 32'hcf);
    chk(32'(ep), 32'h7);
    chk(32'({dir, circ}), 32'h3);
    rw(CTRL_IDX, 8'h05, 32'h05);
    chk(32'({dir, circ, ep}), 32'h05);
    apb(1'b1, 16'hfff3, 8'hff);
    chk(32'(err), 32'h1);
    apb(1'b0, 16'hfff3, 8'h00);
    chk({rd[30:0], err}, 32'h1);
    chk({31'h0, pready}, 32'h1);
    $display("registers done");
  endtask : t_regs

  task automatic t_in;
    int c;
    apb(1'b1, SLOT_LO_IDX, 8'h08);
    for (c = 0; c < 4; c++) begin
      apb(1'b1, CTRL_IDX, 8'h09);
      apb(1'b1, SLOT_HI_IDX, {2'(c), 6'h20});
      apb(1'b1, CTRL_IDX, 8'h89);
      slot(4'd13);
      slot(4'd3);
      slot(4'd12);
      slot(4'd4);
      in_tot += 2 * (c + 1);
      chk(32'(usb_got), in_tot);
      chk(32'(usb_last), 32'h10 + in_tot - 1);
    end
    $display("in transfers done");
  endtask : t_in

  task automatic t_gate;
    apb(1'b1, CTRL_IDX, 8'h88);
    slot(4'd13);
    apb(1'b1, CTRL_IDX, 8'h09);
    slot(4'd13);
    apb(1'b1, CTRL_IDX, 8'h89);
    slot(4'd14);
    chk(32'(usb_got), in_tot);
    $display("gating done");
  endtask : t_gate

  task automatic t_out;
    apb(1'b1, CTRL_IDX, 8'h01);
    apb(1'b1, SLOT_HI_IDX, 8'h60);
    apb(1'b1, CTRL_IDX, 8'h81);
    slot(4'd13);
    chk({16'h0, cp_got, cp_last}, 32'h0281);
    chk(32'(usb_got), in_tot);
    $display("out transfer done");
  endtask : t_out

  task automatic t_stall;
    apb(1'b1, CTRL_IDX, 8'h09);
    apb(1'b1, SLOT_HI_IDX, 8'he0);
    apb(1'b1, CTRL_IDX, 8'h89);
    stall <= 1'b1;
    slot(4'd13);
    chk(32'(usb_got), in_tot);
    chk(32'(busy), 32'h1);
    // Busy, two bytes left, buffer full
    apb(1'b0, STATUS_IDX, 8'h00);
    chk(rd, 32'h25);
    stall <= 1'b0;
    repeat (12) @(posedge clk);
    in_tot += 4;
    chk(32'(usb_got), in_tot);
    chk(32'(usb_last), 32'h10 + in_tot - 1);
    $display("stall done");
  endtask : t_stall

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_in;
    t_gate;
    t_out;
    t_stall;
    close_out;
  end

  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out;
  end
endmodule : tb_dma_slot_channel
